// File: adc_regs_pkg.sv
// Purpose: Shared constants and types for the converter result and trigger register block.
// Assumes: AHB-Lite register access, one 32-bit aligned word per 8-bit register.
// Notes: Offsets are byte addresses.
package adc_regs_pkg;

  // Register byte offsets.
  localparam logic [7:0] ctrl0_offset = 8'h00;
  localparam logic [7:0] ctrl1_offset = 8'h04;
  localparam logic [7:0] trig_offset = 8'h08;
  localparam logic [7:0] res_high_offset = 8'h0C;
  localparam logic [7:0] res_low_offset = 8'h10;
  localparam logic [7:0] irq_status_offset = 8'h14;
  localparam logic [7:0] irq_mask_offset = 8'h18;

  // Field positions and widths.
  localparam int format_bit = 7;
  localparam int enable_bit = 0;
  localparam int go_bit = 1;
  localparam int trig_width = 4;
  localparam int result_width = 10;

  // Reset values.
  localparam logic [7:0] ctrl0_reset = 8'h00;
  localparam logic [7:0] ctrl1_reset = 8'h00;
  localparam logic [3:0] trig_reset = 4'h0;

  // Conversion time in cycles of the register clock.
  localparam int conv_time_ns = 2000;
  localparam int clk_period_ns = 50;
  localparam int conv_cycles = conv_time_ns / clk_period_ns;

  // Formatted result pair.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_type;

  // Sequencer states.
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_conv = 2'b10
  } conv_state_type;

endpackage : adc_regs_pkg

// File: adc_result_and_trigger_regs.sv
// Purpose: Register-side logic of a 10-bit converter: trigger select, edge start, result formatting.
// Assumes: The analog core delivers a 10-bit sample when asked; AHB-Lite single word transfers.
// Notes: Result registers are not reset; they keep their value through the block reset.
module adc_result_and_trigger_regs #(
  parameter int trig_sources = 16,
  parameter int conv_len = adc_regs_pkg::conv_cycles
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger sources from other peripherals, asynchronous to this block.
  input wire logic [trig_sources-1:0] trig_in,
  // Analog core.
  input wire logic [adc_regs_pkg::result_width-1:0] sample_in,
  output logic [5:0] channel_select,
  output logic sample_req,
  // Interrupt.
  output logic irq
);

  logic rst_s1_r;
  logic rst_sync_n;
  logic [trig_sources-1:0] trig_s1_r;
  logic [trig_sources-1:0] trig_s2_r;
  logic [trig_sources-1:0] trig_d_r;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [3:0] trig_sel_r;
  logic [7:0] res_high_r;
  logic [7:0] res_low_r;
  logic done_flag_r;
  logic done_en_r;
  logic [15:0] cnt_r;
  logic [15:0] req_cycles_r;
  adc_regs_pkg::conv_state_type state_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rd_pend_r;
  logic [7:0] rd_addr_r;
  logic auto_start;
  logic start;
  logic finish;
  logic wr_go;
  adc_regs_pkg::result_pair_type fmt;

  // Format a raw sample into the high/low pair.
  function automatic adc_regs_pkg::result_pair_type format_result(input logic right,
                                                                   input logic [9:0] s);
    adc_regs_pkg::result_pair_type p;
    if (right) begin
      p.high = {6'h00, s[9:8]};
      p.low = s[7:0];
    end else begin
      p.high = s[9:2];
      p.low = {s[1:0], 6'h00};
    end
    return p;
  endfunction : format_result

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // Trigger synchronisers; edge detection compares the second stage with its delayed copy trig_d_r.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trig_s1_r <= '0;
      trig_s2_r <= '0;
      trig_d_r <= '0;
    end else begin
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  // Of the trigger sources, only a low-to-high change of the selected one starts a conversion.
  assign auto_start = trig_s2_r[trig_sel_r] & ~trig_d_r[trig_sel_r] & ctrl0_r[adc_regs_pkg::enable_bit];

  // Bus phase capture; the slave never waits.
  // Address and direction are held for the data phase, since hwdata only arrives one cycle later.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      rd_pend_r <= hsel & htrans[1] & ~hwrite;
      wr_addr_r <= haddr[7:0];
      rd_addr_r <= haddr[7:0];
    end
  end

  assign wr_go = wr_pend_r && wr_addr_r == adc_regs_pkg::ctrl0_offset && hwdata[adc_regs_pkg::go_bit];
  assign start = (state_r == adc_regs_pkg::st_idle) && ctrl0_r[adc_regs_pkg::enable_bit] && (auto_start || wr_go);
  assign finish = (state_r == adc_regs_pkg::st_conv) && cnt_r == 16'(conv_len - 1);

  // Conversion sequencer.
  // Triggers and go writes that arrive while busy are dropped, not queued.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= adc_regs_pkg::st_idle;
      cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        adc_regs_pkg::st_idle: begin
          cnt_r <= 16'h0000;
          if (start) begin
            state_r <= adc_regs_pkg::st_conv;
          end
        end
        adc_regs_pkg::st_conv: begin
          cnt_r <= cnt_r + 16'h0001;
          if (finish) begin
            state_r <= adc_regs_pkg::st_idle;
          end
        end
        default: state_r <= adc_regs_pkg::st_idle;
      endcase
    end
  end
  assign sample_req = (state_r == adc_regs_pkg::st_conv);
  assign channel_select = ctrl0_r[7:2];

  // Length of the current sample request, kept apart from the sequencer so its check does not reuse cnt_r.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_cycles_r <= 16'h0000;
    end else if (sample_req) begin
      req_cycles_r <= req_cycles_r + 16'h0001;
    end else begin
      req_cycles_r <= 16'h0000;
    end
  end

  // Control registers; the go bit self-clears when the conversion ends.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl0_r <= adc_regs_pkg::ctrl0_reset;
      ctrl1_r <= adc_regs_pkg::ctrl1_reset;
      trig_sel_r <= adc_regs_pkg::trig_reset;
      done_en_r <= 1'b0;
    end else begin
      if (start) begin
        ctrl0_r[adc_regs_pkg::go_bit] <= 1'b1;
      end else if (finish) begin
        ctrl0_r[adc_regs_pkg::go_bit] <= 1'b0;
      end
      if (wr_pend_r) begin
        case (wr_addr_r)
          adc_regs_pkg::ctrl0_offset: begin
            ctrl0_r[7:2] <= hwdata[7:2];
            ctrl0_r[adc_regs_pkg::enable_bit] <= hwdata[adc_regs_pkg::enable_bit];
          end
          adc_regs_pkg::ctrl1_offset: ctrl1_r <= hwdata[7:0] & 8'hF3;
          adc_regs_pkg::trig_offset: trig_sel_r <= hwdata[3:0];
          adc_regs_pkg::irq_mask_offset: done_en_r <= hwdata[0];
          default: ;
        endcase
      end
    end
  end

  // Result pair: no reset, so other resets leave it untouched.
  assign fmt = format_result(ctrl1_r[adc_regs_pkg::format_bit], sample_in);
  always_ff @(posedge ref_clk) begin
    if (finish) begin
      res_high_r <= fmt.high;
      res_low_r <= fmt.low;
    end else if (wr_pend_r && wr_addr_r == adc_regs_pkg::res_high_offset) begin
      res_high_r <= hwdata[7:0];
    end else if (wr_pend_r && wr_addr_r == adc_regs_pkg::res_low_offset) begin
      res_low_r <= hwdata[7:0];
    end
  end

  // Done flag: set wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_flag_r <= 1'b0;
    end else if (finish) begin
      done_flag_r <= 1'b1;
    end else if (wr_pend_r && wr_addr_r == adc_regs_pkg::irq_status_offset && hwdata[0]) begin
      done_flag_r <= 1'b0;
    end
  end
  assign irq = done_flag_r & done_en_r;

  // Read data multiplexer; unmapped offsets read zero.
  // Outside a read data phase the bus sees zero, so stale register values never leak out.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_r) begin
      case (rd_addr_r)
        adc_regs_pkg::ctrl0_offset: hrdata[7:0] = ctrl0_r;
        adc_regs_pkg::ctrl1_offset: hrdata[7:0] = ctrl1_r;
        adc_regs_pkg::trig_offset: hrdata[7:0] = {4'h0, trig_sel_r};
        adc_regs_pkg::res_high_offset: hrdata[7:0] = res_high_r;
        adc_regs_pkg::res_low_offset: hrdata[7:0] = res_low_r;
        adc_regs_pkg::irq_status_offset: hrdata[0] = done_flag_r;
        adc_regs_pkg::irq_mask_offset: hrdata[0] = done_en_r;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Assertions.
  // They are disabled while the internal reset is low, because the result pair is unknown until written.
  // Helper counter req_cycles_r is the only logic here that exists just for checking.
  a_edge_starts_conv: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state_r == adc_regs_pkg::st_idle && ctrl0_r[0] && trig_s2_r[trig_sel_r] && !trig_d_r[trig_sel_r])
      |=> state_r == adc_regs_pkg::st_conv) else $error("Rising trigger edge did not start a conversion.");
  a_level_no_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state_r == adc_regs_pkg::st_idle && !wr_go && !(trig_s2_r[trig_sel_r] && !trig_d_r[trig_sel_r]))
      |=> state_r == adc_regs_pkg::st_idle) else $error("Conversion started without an edge.");
  a_trig_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (rd_pend_r && rd_addr_r == adc_regs_pkg::trig_offset) |-> hrdata[31:4] == 28'h0)
    else $error("Trigger upper bits not zero.");
  a_left_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && !ctrl1_r[7]) |=> res_high_r == $past(sample_in[9:2])) else $error("Left high wrong.");
  a_left_low: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && !ctrl1_r[7]) |=> res_low_r[7:6] == $past(sample_in[1:0])) else $error("Left low wrong.");
  a_right_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && ctrl1_r[7]) |=> res_high_r[1:0] == $past(sample_in[9:8])) else $error("Right high wrong.");
  a_right_low: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && ctrl1_r[7]) |=> res_low_r == $past(sample_in[7:0])) else $error("Right low wrong.");
  a_result_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_pend_r && wr_addr_r == adc_regs_pkg::res_low_offset && !finish) |=> res_low_r == $past(hwdata[7:0]))
    else $error("Result low write lost.");
  a_conv_length: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    start |=> sample_req [*2] ##[0:1000] finish) else $error("Conversion did not finish in time.");
  a_done_irq: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    finish |=> done_flag_r && (irq == done_en_r)) else $error("Done flag or interrupt wrong.");
  // The go bit drops on the edge that raises the done flag.
  a_go_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    finish |=> !ctrl0_r[adc_regs_pkg::go_bit])
    else $error("Go bit did not clear at the end of a conversion.");
  // Reserved low-register bits load as zero in left format.
  a_left_reserved: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && !ctrl1_r[adc_regs_pkg::format_bit]) |=> res_low_r[5:0] == 6'h00)
    else $error("Left format reserved bits not zero.");
  // Reserved high-register bits load as zero in right format.
  a_right_reserved: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (finish && ctrl1_r[adc_regs_pkg::format_bit]) |=> res_high_r[7:2] == 6'h00)
    else $error("Right format reserved bits not zero.");
  // The done flag only rises on the same edge that loads the result pair.
  a_done_after_result: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $rose(done_flag_r) |-> $past(finish))
    else $error("Done flag rose without a finished conversion.");
  // No interrupt while its enable is clear.
  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    !done_en_r |-> !irq)
    else $error("Interrupt raised while disabled.");
  // A trigger register write lands in the select field.
  a_trig_select_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_pend_r && wr_addr_r == adc_regs_pkg::trig_offset) |=> trig_sel_r == $past(hwdata[3:0]))
    else $error("Trigger select write lost.");
  // The sequencer state stays one-hot.
  a_state_onehot: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $onehot(state_r))
    else $error("Sequencer state not one-hot.");
  // The sample request lasts exactly the conversion length.
  a_conv_cycles: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $fell(sample_req) |-> $past(req_cycles_r) == 16'(conv_len - 1))
    else $error("Sample request length wrong.");
  // A software write to the high result register lands when no result is loaded.
  a_result_high_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_pend_r && wr_addr_r == adc_regs_pkg::res_high_offset && !finish) |=> res_high_r == $past(hwdata[7:0]))
    else $error("Result high write lost.");
  // A running conversion is not cut short or restarted by new edges.
  a_busy_holds: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state_r == adc_regs_pkg::st_conv && !finish) |=> state_r == adc_regs_pkg::st_conv)
    else $error("Busy conversion left early.");
  // The read bus rests at zero outside a read data phase.
  a_hrdata_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    !rd_pend_r |-> hrdata == 32'h0000_0000)
    else $error("Read data not zero outside a read.");

endmodule : adc_result_and_trigger_regs

// File: adc_result_and_trigger_regs_test.sv
// Purpose: Self-checking bench for the converter result and trigger register block.
// Assumes: Zero-wait AHB-Lite slave; conversion length cut to four cycles to keep the run short.
// Notes: Table rows cover both result formats; trigger, interrupt and reset cases follow by hand.
module adc_result_and_trigger_regs_test;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic fmt;
    logic [9:0] smp;
    logic [7:0] hi;
    logic [7:0] lo;
  } row_type;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] trig_in = 16'h0;
  logic [9:0] sample_in = 10'h0;
  logic hready, hreadyout, hresp, sample_req, irq;
  logic [31:0] hrdata, rd;
  logic [5:0] channel_select;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] zero_regs [6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1C};
  row_type rows [6] = '{'{1'b0, 10'h3FF, 8'hFF, 8'hC0}, '{1'b0, 10'h2A5, 8'hA9, 8'h40},
    '{1'b1, 10'h2A5, 8'h02, 8'hA5}, '{1'b1, 10'h15A, 8'h01, 8'h5A},
    '{1'b0, 10'h001, 8'h00, 8'h40}, '{1'b1, 10'h300, 8'h03, 8'h00}};

  // The single slave's ready output is the bus ready.
  assign hready = hreadyout;

  adc_result_and_trigger_regs #(.trig_sources(16), .conv_len(4)) u_adc_result_and_trigger_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trig_in(trig_in), .sample_in(sample_in), .channel_select(channel_select),
    .sample_req(sample_req), .irq(irq));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits for an edge with ready high; a stuck slave ends the run instead of hanging it.
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        $display("ERROR %0t: bus ready never came", $time);
        tally_and_finish();
      end
      @(posedge ref_clk);
    end
  endtask : wait_ready

  // One single-word transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, addr};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
  endtask : bus

  // Polls the status register until the done bit shows, with a bounded number of reads.
  task automatic wait_done;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, adc_regs_pkg::irq_status_offset, 32'h0, rd);
      if (rd[0] === 1'b1) begin
        return;
      end
    end
    num_errors++;
    $display("ERROR %0t: conversion never finished", $time);
    tally_and_finish();
  endtask : wait_done

  // Main sequence: reset values, format table, trigger, interrupt, result storage and reset.
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (zero_regs[i]) begin
      bus(1'b0, zero_regs[i], 32'h0, rd);
      chk(rd, 32'h0);
    end
    chk({31'h0, hresp}, 32'h0);
    // A go write only starts when the enable bit is already set.
    bus(1'b1, adc_regs_pkg::ctrl0_offset, 32'h01, rd);
    foreach (rows[i]) begin
      sample_in <= rows[i].smp;
      bus(1'b1, adc_regs_pkg::ctrl1_offset, {24'h0, rows[i].fmt, 7'h00}, rd);
      bus(1'b1, adc_regs_pkg::ctrl0_offset, 32'h03, rd);
      @(negedge ref_clk);
      chk({31'h0, sample_req}, 32'h1);
      wait_done();
      chk({31'h0, sample_req}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, adc_regs_pkg::res_high_offset, 32'h0, rd);
      chk(rd, {24'h0, rows[i].hi});
      bus(1'b0, adc_regs_pkg::res_low_offset, 32'h0, rd);
      chk(rd, {24'h0, rows[i].lo});
      bus(1'b1, adc_regs_pkg::irq_status_offset, 32'h1, rd);
    end
    // Unselected sources must not start; a level held high must not restart.
    bus(1'b1, adc_regs_pkg::trig_offset, 32'hFF, rd);
    bus(1'b0, adc_regs_pkg::trig_offset, 32'h0, rd);
    chk(rd, 32'h0F);
    bus(1'b1, adc_regs_pkg::trig_offset, 32'h05, rd);
    bus(1'b1, adc_regs_pkg::ctrl0_offset, 32'hA5, rd);
    bus(1'b0, adc_regs_pkg::ctrl0_offset, 32'h0, rd);
    chk(rd, 32'hA5);
    chk({26'h0, channel_select}, 32'h29);
    trig_in <= 16'h0008;
    repeat (12) @(posedge ref_clk);
    bus(1'b0, adc_regs_pkg::irq_status_offset, 32'h0, rd);
    chk(rd, 32'h0);
    trig_in <= 16'h0028;
    wait_done();
    bus(1'b1, adc_regs_pkg::irq_mask_offset, 32'h1, rd);
    bus(1'b0, adc_regs_pkg::irq_mask_offset, 32'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, adc_regs_pkg::irq_status_offset, 32'h1, rd);
    repeat (12) @(posedge ref_clk);
    bus(1'b0, adc_regs_pkg::irq_status_offset, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Result registers are writable and keep their contents through a block reset.
    bus(1'b1, adc_regs_pkg::res_high_offset, 32'hA6, rd);
    bus(1'b1, adc_regs_pkg::res_low_offset, 32'h3C, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, adc_regs_pkg::res_high_offset, 32'h0, rd);
    chk(rd, 32'hA6);
    bus(1'b0, adc_regs_pkg::res_low_offset, 32'h0, rd);
    chk(rd, 32'h3C);
    bus(1'b0, adc_regs_pkg::trig_offset, 32'h0, rd);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : adc_result_and_trigger_regs_test
